// ### rcg_pkg.sv
// package for the receive condition b write guard block
// assumes a byte-wide control bus with one access strobe per cycle
package rcg_pkg;
  localparam logic [4:0] RCG_ADDR_RCB_SNAPSHOT = 5'h1D;
  localparam logic [4:0] RCG_ADDR_RCB_FLAGS = 5'h11;
  localparam logic [4:0] RCG_ADDR_MODE_TWO = 5'h1E;
  localparam logic [4:0] RCG_ADDR_INT_COND = 5'h02;
  localparam logic [7:0] RCG_RESET_BYTE = 8'h00;
  // interrupt condition bits owned here
  localparam int RCG_ICR_CPE_BIT = 1;
  localparam int RCG_ICR_CWI_BIT = 3;
  // mode two fields
  localparam int RCG_M2_SOFT_RST_BIT = 0;
  localparam int RCG_M2_PAR_EN_BIT = 1;
  localparam int RCG_M2_CLK_SEL_BIT = 5;
  localparam int RCG_M2_SCRUB_BIT = 7;
  localparam logic [7:0] RCG_M2_WRITABLE = 8'hA3;
  // soft reset holds for 32 byte times
  localparam int RCG_SOFT_RST_BYTES = 32;
  localparam int RCG_SOFT_RST_CYC = RCG_SOFT_RST_BYTES;

  typedef struct packed {
    logic super_idle_flag;
    logic elastic_buffer_fault_flag;
    logic reserved_flag;
    logic cascade_sync_or_service_event;
    logic unknown_line_valid_flag;
    logic active_line_flag;
    logic dwell_threshold_flag;
    logic idle_line_flag;
  } rcg_flags_raw_t;

  // host access bundle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
    logic parity;
  } rcg_cbus_t;
endpackage

// ### rcg_guard.sv
// receive condition b write guard: flags, snapshot, mode two register
// assumes bus signals are synchronous to sys_clk_i (one byte clock)
`timescale 1ns/1ps
module rcg_guard
  import rcg_pkg::*;
#(
  parameter int SOFT_RST_CYC = RCG_SOFT_RST_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cbus_rd_i,
  input wire logic cbus_wr_i,
  input wire logic [4:0] cbus_addr_i,
  input wire logic [7:0] cbus_wdata_i,
  input wire logic cbus_wpar_i,
  input wire logic [7:0] cond_set_i,
  output logic [7:0] cbus_rdata_o,
  output logic cbus_rpar_o,
  output logic [7:0] receive_condition_b_flags_o,
  output logic [7:0] receive_condition_b_snapshot_o,
  output logic write_inhibit_flag_o,
  output logic control_port_parity_error_o,
  output logic protocol_soft_reset_o,
  output logic aux_clock_rate_choice_o,
  output logic trigger_scrub_enable_o
);
  localparam int CW = $clog2(SOFT_RST_CYC + 1);

  logic [7:0] flags_q, flags_d;
  logic [7:0] snap_q;
  logic [7:0] device_mode_control_two_q, device_mode_control_two_d;
  logic [1:0] icr_q, icr_d;
  logic [CW-1:0] rst_cnt_q;
  logic [7:0] rdata_q;
  logic rpar_q;

  // odd parity over the written byte
  wire par_ok = (^cbus_wdata_i) ^ cbus_wpar_i;
  wire par_bad = device_mode_control_two_q[RCG_M2_PAR_EN_BIT] && !par_ok;
  wire wr_ok = cbus_wr_i && !par_bad;
  wire wr_flags = wr_ok && (cbus_addr_i == RCG_ADDR_RCB_FLAGS);
  wire wr_snap = wr_ok && (cbus_addr_i == RCG_ADDR_RCB_SNAPSHOT);
  wire wr_device_mode_control_two = wr_ok && (cbus_addr_i == RCG_ADDR_MODE_TWO);
  wire wr_icr = wr_ok && (cbus_addr_i == RCG_ADDR_INT_COND);
  wire rd_flags = cbus_rd_i && (cbus_addr_i == RCG_ADDR_RCB_FLAGS);
  // host must have read flags before writing; otherwise mismatch
  wire [7:0] stale = flags_q ^ snap_q;
  wire inhibit = wr_flags && (stale != 8'h00);
  wire rst_done = protocol_soft_reset_o && (rst_cnt_q == CW'(SOFT_RST_CYC - 1));

  always_comb begin
    // mismatched bits keep live value, others take the write
    flags_d = (flags_q & stale) | (cbus_wdata_i & ~stale);
    if (!wr_flags) begin
      flags_d = flags_q;
    end
    // hardware events win over a clearing write
    flags_d = flags_d | cond_set_i;
    if (protocol_soft_reset_o) begin
      flags_d = RCG_RESET_BYTE;
    end
  end

  always_comb begin
    device_mode_control_two_d = device_mode_control_two_q;
    if (wr_device_mode_control_two) begin
      // soft reset bit can only be set by the host
      device_mode_control_two_d = (cbus_wdata_i & RCG_M2_WRITABLE & ~8'h01)
        | (device_mode_control_two_q & 8'h01) | (cbus_wdata_i & 8'h01);
    end
    if (rst_done) begin
      device_mode_control_two_d[RCG_M2_SOFT_RST_BIT] = 1'b0;
    end
  end

  always_comb begin
    icr_d = icr_q;
    if (wr_icr) begin
      // write one to clear
      icr_d = icr_q & ~{cbus_wdata_i[RCG_ICR_CWI_BIT],
        cbus_wdata_i[RCG_ICR_CPE_BIT]};
    end
    if (inhibit) begin
      icr_d[1] = 1'b1;
    end
    if (cbus_wr_i && par_bad) begin
      icr_d[0] = 1'b1;
    end
  end

  wire [7:0] icr_view = ({7'h00, icr_q[1]} << RCG_ICR_CWI_BIT)
    | ({7'h00, icr_q[0]} << RCG_ICR_CPE_BIT);
  wire [7:0] rd_mux =
    (cbus_addr_i == RCG_ADDR_RCB_FLAGS) ? flags_q :
    (cbus_addr_i == RCG_ADDR_RCB_SNAPSHOT) ? snap_q :
    (cbus_addr_i == RCG_ADDR_MODE_TWO) ? device_mode_control_two_q :
    (cbus_addr_i == RCG_ADDR_INT_COND) ? icr_view : RCG_RESET_BYTE;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= RCG_RESET_BYTE;
      snap_q <= RCG_RESET_BYTE;
      device_mode_control_two_q <= RCG_RESET_BYTE;
      icr_q <= 2'h0;
    end else begin
      flags_q <= flags_d;
      device_mode_control_two_q <= device_mode_control_two_d;
      icr_q <= icr_d;
      // snapshot maps bit for bit onto the flags
      if (rd_flags) begin
        snap_q <= flags_q;
      end else if (wr_snap) begin
        snap_q <= cbus_wdata_i;
      end else if (protocol_soft_reset_o) begin
        snap_q <= RCG_RESET_BYTE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_cnt_q <= '0;
    end else if (protocol_soft_reset_o && !rst_done) begin
      rst_cnt_q <= rst_cnt_q + CW'(1);
    end else begin
      rst_cnt_q <= '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= RCG_RESET_BYTE;
      rpar_q <= 1'b1;
    end else if (cbus_rd_i) begin
      rdata_q <= rd_mux;
      rpar_q <= ~(^rd_mux);
    end
  end

  assign receive_condition_b_flags_o = flags_q;
  assign receive_condition_b_snapshot_o = snap_q;
  assign write_inhibit_flag_o = icr_q[1];
  assign control_port_parity_error_o = icr_q[0];
  assign protocol_soft_reset_o = device_mode_control_two_q[RCG_M2_SOFT_RST_BIT];
  assign aux_clock_rate_choice_o = device_mode_control_two_q[RCG_M2_CLK_SEL_BIT];
  assign trigger_scrub_enable_o = device_mode_control_two_q[RCG_M2_SCRUB_BIT];
  assign cbus_rdata_o = rdata_q;
  assign cbus_rpar_o = rpar_q;

  property p_snap_copy;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_flags |=> snap_q == $past(flags_q);
  endproperty
  a_snap_copy: assert property (p_snap_copy)
    else $error("snapshot not loaded on flags read");

  property p_inhibit_set;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    inhibit |=> write_inhibit_flag_o;
  endproperty
  a_inhibit_set: assert property (p_inhibit_set)
    else $error("inhibit flag not raised");

  property p_stale_kept;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_flags && !protocol_soft_reset_o) |=>
      // a hardware event in the same cycle may still set a protected bit
      ((flags_q & $past(stale))
        == (($past(flags_q) | $past(cond_set_i)) & $past(stale)));
  endproperty
  a_stale_kept: assert property (p_stale_kept)
    else $error("mismatched flag bit changed by write");

  property p_match_apply;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_flags && stale == 8'h00 && !protocol_soft_reset_o
      && !wr_icr && !par_bad)
      |=> (flags_q == ($past(cbus_wdata_i) | $past(cond_set_i)))
      && (write_inhibit_flag_o == $past(write_inhibit_flag_o));
  endproperty
  a_match_apply: assert property (p_match_apply)
    else $error("matching write not applied");

  property p_soft_rst_len;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(protocol_soft_reset_o) |-> ##[1:40] !protocol_soft_reset_o;
  endproperty
  a_soft_rst_len: assert property (p_soft_rst_len)
    else $error("soft reset did not self clear");

  property p_par_err;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (cbus_wr_i && par_bad) |=> control_port_parity_error_o
      && $stable(device_mode_control_two_q[7:1]);
  endproperty
  a_par_err: assert property (p_par_err)
    else $error("parity error not flagged or access kept");

  property p_snap_bits;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_flags |=> snap_q[4] == $past(flags_q[4])
      && snap_q[5] == $past(flags_q[5]) && snap_q[7:6] == $past(flags_q[7:6]);
  endproperty
  a_snap_bits: assert property (p_snap_bits)
    else $error("snapshot bit layout wrong");

  property p_snap_low;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_flags |=> snap_q[3:0] == $past(flags_q[3:0]);
  endproperty
  a_snap_low: assert property (p_snap_low)
    else $error("snapshot low bits wrong");
endmodule

// ### rcg_host.sv
// host model: single byte reads and writes on the control bus
// assumes the device samples strobes on the rising edge of sys_clk_i
`timescale 1ns/1ps
module rcg_host (
  input wire logic sys_clk_i,
  input wire logic [7:0] cbus_rdata_i,
  output logic cbus_rd_o,
  output logic cbus_wr_o,
  output logic [4:0] cbus_addr_o,
  output logic [7:0] cbus_wdata_o,
  output logic cbus_wpar_o
);
  initial begin
    cbus_rd_o = 1'b0;
    cbus_wr_o = 1'b0;
    cbus_addr_o = 5'h00;
    cbus_wdata_o = 8'h00;
    cbus_wpar_o = 1'b1;
  end
  // bad flips the odd parity on purpose
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic bad);
    @(posedge sys_clk_i);
    cbus_wr_o <= 1'b1;
    cbus_addr_o <= a;
    cbus_wdata_o <= d;
    cbus_wpar_o <= ~^d ^ bad;
    @(posedge sys_clk_i);
    cbus_wr_o <= 1'b0;
    // released data must not keep looking valid
    cbus_wdata_o <= ~d;
  endtask
  // a read of the flags address arms the snapshot before the host writes flags back
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    @(posedge sys_clk_i);
    cbus_rd_o <= 1'b1;
    cbus_addr_o <= a;
    @(posedge sys_clk_i);
    cbus_rd_o <= 1'b0;
    @(posedge sys_clk_i);
    #1 q = cbus_rdata_i;
  endtask
endmodule

// ### rx_cond_b_write_guard_tb.sv
// testbench for the receive condition b write guard
// assumes rcg_pkg and rcg_guard compiled first; host model drives the bus
`timescale 1ns/1ps
module rx_cond_b_write_guard_tb;
  import rcg_pkg::*;
  localparam int SRC = 4;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] cond_set_i = 8'h00;
  logic cbus_rd_i, cbus_wr_i, cbus_wpar_i, cbus_rpar_o;
  logic [4:0] cbus_addr_i;
  logic [7:0] cbus_wdata_i, cbus_rdata_o, flg, snp, q;
  logic inh, perr, srst, aux, scrub;
  int err_count = 0;
  int n_compared = 0;
  int i;
  int n;
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  rcg_host i_host (
    .sys_clk_i,
    .cbus_rdata_i(cbus_rdata_o),
    .cbus_rd_o(cbus_rd_i),
    .cbus_wr_o(cbus_wr_i),
    .cbus_addr_o(cbus_addr_i),
    .cbus_wdata_o(cbus_wdata_i),
    .cbus_wpar_o(cbus_wpar_i)
  );
  rcg_guard #(.SOFT_RST_CYC(SRC)) i_dut (
    .sys_clk_i, .reset_n_i, .cbus_rd_i, .cbus_wr_i, .cbus_addr_i,
    .cbus_wdata_i, .cbus_wpar_i, .cond_set_i, .cbus_rdata_o,
    .cbus_rpar_o,
    .receive_condition_b_flags_o(flg),
    .receive_condition_b_snapshot_o(snp),
    .write_inhibit_flag_o(inh),
    .control_port_parity_error_o(perr),
    .protocol_soft_reset_o(srst),
    .aux_clock_rate_choice_o(aux),
    .trigger_scrub_enable_o(scrub)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic settle();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge sys_clk_i);
    cond_set_i <= v;
    @(posedge sys_clk_i);
    cond_set_i <= 8'h00;
  endtask
  initial begin
    #50000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    settle();
    check(flg, RCG_RESET_BYTE);
    check({snp[7:1], cbus_rpar_o}, 8'h01);
    // host writes without reading first: bits 0 and 2 are protected
    pulse(8'h05);
    i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h12, 1'b0);
    settle();
    check(flg, 8'h17);
    check({7'h00, inh}, 8'h01);
    i_host.rd(RCG_ADDR_INT_COND, q);
    check(q, 8'h08);
    i_host.wr(RCG_ADDR_INT_COND, 8'h08, 1'b0);
    i_host.rd(RCG_ADDR_RCB_FLAGS, q);
    check(q, 8'h17);
    check(snp, 8'h17);
    check({7'h00, inh}, 8'h00);
    i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h00, 1'b0);
    settle();
    check({flg[7:1], inh}, 8'h00);
    for (i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      i_host.rd(RCG_ADDR_RCB_FLAGS, q);
      check(snp, 8'h01 << i);
      i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h00, 1'b0);
    end
    i_host.rd(5'h1F, q);
    check(q, 8'h00);
    pulse(8'h40);
    i_host.wr(RCG_ADDR_MODE_TWO, 8'h01, 1'b0);
    settle();
    n = 0;
    while (srst === 1'b1 && n < 50) begin
      settle();
      n++;
    end
    // high for SRC edges; the first one passes before the loop starts
    check(8'(n), 8'(SRC - 1));
    check(flg, 8'h00);
    i_host.wr(RCG_ADDR_MODE_TWO, 8'h02, 1'b0);
    i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h20, 1'b1);
    settle();
    check({flg[7:1], perr}, 8'h01);
    i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h20, 1'b0);
    settle();
    check(flg, 8'h20);
    i_host.rd(RCG_ADDR_INT_COND, q);
    check(q, 8'h02);
    check({7'h00, cbus_rpar_o}, 8'h00);
    // reserved mode bits stay zero, parity enable stays set
    i_host.wr(RCG_ADDR_MODE_TWO, 8'hFE, 1'b0);
    i_host.rd(RCG_ADDR_MODE_TWO, q);
    check(q, 8'hA2);
    check({6'h00, aux, scrub}, 8'h03);
    // a snapshot written by the host makes bits 0..3 and 5 protected
    i_host.wr(RCG_ADDR_RCB_SNAPSHOT, 8'h0F, 1'b0);
    i_host.wr(RCG_ADDR_RCB_FLAGS, 8'h00, 1'b0);
    settle();
    check(snp, 8'h0F);
    check(flg, 8'h20);
    check({7'h00, inh}, 8'h01);
    conclude();
  end
endmodule
